/* File: src/lsr_pkg.sv */
// package: constants and carrier types for the load switch reset sequencer
package lsr_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned OFF_DELAY_US = 900000;       // switch_off_delay, delayed
    localparam int unsigned OFF_FAST_US = 600;           // switch_off_delay, zero-second
    localparam int unsigned ON_DELAY_US = 38000;         // button_turn_on_delay
    localparam int unsigned ON_FAST_US = 4000;           // button_turn_on_delay, test mode
    localparam int unsigned LONG_PRESS_US = 11500000;    // long_press_delay
    localparam int unsigned LONG_FAST_US = 1000;         // long_press_delay, test mode
    localparam int unsigned LOCKOUT_US = 400000;         // post_reset_lockout
    localparam int unsigned CYC_PER_US = CLK_HZ / 1000000;
    localparam int unsigned OFF_DELAY_CYC = OFF_DELAY_US * CYC_PER_US;
    localparam int unsigned OFF_FAST_CYC = OFF_FAST_US * CYC_PER_US;
    localparam int unsigned ON_DELAY_CYC = ON_DELAY_US * CYC_PER_US;
    localparam int unsigned ON_FAST_CYC = ON_FAST_US * CYC_PER_US;
    localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_US * CYC_PER_US;
    localparam int unsigned LONG_FAST_CYC = LONG_FAST_US * CYC_PER_US;
    localparam int unsigned LOCKOUT_CYC = LOCKOUT_US * CYC_PER_US;
    localparam int unsigned TMR_W = 30;
    // input and switch state after power-on reset
    localparam logic RST_BUTTON_N = 1'b1;
    localparam logic RST_DELAY_SEL = 1'b1;
    localparam logic RST_WAKE = 1'b0;
    localparam logic RST_SHUTDOWN = 1'b1;
    localparam logic RST_SWITCH_ON = 1'b1;

    typedef struct packed {
        logic power_button_n;
        logic wake_request;
        logic shutdown_request;
        logic delay_select;
    } lsr_inputs_t;

    typedef enum logic [2:0] {
        ST_ON_IDLE,
        ST_OFF_WAIT,
        ST_LONG_PRESS,
        ST_LOCKOUT,
        ST_OFF_IDLE,
        ST_ON_WAIT
    } lsr_state_t;
endpackage : lsr_pkg

/* File: src/lsr_sync.sv */
// two-stage synchroniser for the input pins, with reset value per bit
`timescale 1ns/1ps
module lsr_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk, // system clock
    input wire logic reset, // synchronous reset
    input wire logic [WIDTH-1:0] d, // raw pins
    output logic [WIDTH-1:0] q // synchronised pins
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    initial begin
        if (WIDTH < 1) $error("lsr_sync: WIDTH must be positive");
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_r <= INIT;
            q_r <= INIT;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule : lsr_sync

/* File: src/lsr_sequencer.sv */
// load switch on/off and long-press reset sequencer
`timescale 1ns/1ps
// Operation
// - delay high: shutdown falling edge, 900 ms off
// - higher request aborts delayed turn-off
// - delay low: shutdown edge, 0.6 ms off
// - off: wake high or 38 ms press
// - turning on disables reset until release
// - button release re-arms reset, clears counter
// - on, held 11.5 s: switch off
// - after long-press off, 400 ms lock-out
// - after reset, wait for button release
// - early release clears counter, stays on
// - power-on reset ends with switch on
// - reset input state 1,1,0,1, on
// - delay low before press: 4 ms on
// - delay low before press: 1 ms off
// - test mode lock-out stays 400 ms
// - priority: button, wake, shutdown
// - shutdown low at reset counts as edge
module lsr_sequencer
    import lsr_pkg::*;
#(
    parameter int unsigned OFF_DELAY = lsr_pkg::OFF_DELAY_CYC,
    parameter int unsigned OFF_FAST = lsr_pkg::OFF_FAST_CYC,
    parameter int unsigned ON_DELAY = lsr_pkg::ON_DELAY_CYC,
    parameter int unsigned ON_FAST = lsr_pkg::ON_FAST_CYC,
    parameter int unsigned LONG_PRESS = lsr_pkg::LONG_PRESS_CYC,
    parameter int unsigned LONG_FAST = lsr_pkg::LONG_FAST_CYC,
    parameter int unsigned LOCKOUT = lsr_pkg::LOCKOUT_CYC
) (
    input wire logic clk, // 50 MHz system clock
    input wire logic reset, // power-on reset, synchronous, active high
    input wire lsr_pkg::lsr_inputs_t pins, // raw input pins
    output logic switch_on, // load switch command, 1 = closed
    output logic lockout_active // high during post-reset lock-out
);
    import lsr_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    initial begin
        if (OFF_DELAY < 1 || OFF_FAST < 1 || ON_DELAY < 1 || ON_FAST < 1)
            $error("lsr_sequencer: delays must be at least one cycle");
        if (LONG_PRESS < 1 || LONG_FAST < 1 || LOCKOUT < 1)
            $error("lsr_sequencer: delays must be at least one cycle");
        if (LONG_PRESS >= (1 << TMR_W) || OFF_DELAY >= (1 << TMR_W) || LOCKOUT >= (1 << TMR_W))
            $error("lsr_sequencer: delay exceeds timer width");
        if (ON_DELAY >= (1 << TMR_W) || ON_FAST >= (1 << TMR_W))
            $error("lsr_sequencer: delay exceeds timer width");
        if (OFF_FAST >= (1 << TMR_W) || LONG_FAST >= (1 << TMR_W))
            $error("lsr_sequencer: delay exceeds timer width");
    end

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    localparam logic [3:0] SYNC_INIT = {RST_BUTTON_N, RST_WAKE, RST_SHUTDOWN, RST_DELAY_SEL};

    logic [3:0] sync_q;
    lsr_inputs_t in_s;

    lsr_sync #(.WIDTH(4), .INIT(SYNC_INIT)) u_sync (
        .clk(clk),
        .reset(reset),
        .d(pins),
        .q(sync_q)
    );
    assign in_s = lsr_inputs_t'(sync_q);

    // ------------------------------------------------------------
    // stored pin state and edge detection
    // ------------------------------------------------------------
    lsr_inputs_t prev_r;
    lsr_state_t state_r;
    lsr_state_t state_nxt;
    logic [TMR_W-1:0] tmr_r;
    logic [TMR_W-1:0] tmr_nxt;
    logic [TMR_W-1:0] target_r;
    logic [TMR_W-1:0] target_nxt;
    logic armed_r;
    logic armed_nxt;
    logic need_release_r;
    logic need_release_nxt;
    logic switch_on_r;
    logic switch_on_nxt;
    logic lockout_r;
    logic lockout_nxt;

    // stored shutdown resets high, so a low pin at release reads as an edge
    wire button_fall = prev_r.power_button_n & ~in_s.power_button_n;
    wire button_low = ~in_s.power_button_n;
    wire button_rise = ~prev_r.power_button_n & in_s.power_button_n;
    wire wake_rise = ~prev_r.wake_request & in_s.wake_request;
    wire shut_fall = prev_r.shutdown_request & ~in_s.shutdown_request;
    // select sampled before the press: previous-cycle value
    wire sel_low_before = ~prev_r.delay_select;
    wire tmr_done = (tmr_r + 30'h1) >= target_r;

    function automatic logic [TMR_W-1:0] cyc(input int unsigned n);
        cyc = n[TMR_W-1:0];
    endfunction : cyc

    // picks the short or the normal count; the lock-out has no short form
    function automatic logic [TMR_W-1:0] pick(input logic short_sel, input int unsigned short_n,
            input int unsigned long_n);
        pick = short_sel ? cyc(short_n) : cyc(long_n);
    endfunction : pick

    // ------------------------------------------------------------
    // delay selection
    // ------------------------------------------------------------
    wire [TMR_W-1:0] press_target = pick(sel_low_before, LONG_FAST, LONG_PRESS);
    wire [TMR_W-1:0] turn_on_target = pick(sel_low_before, ON_FAST, ON_DELAY);
    wire [TMR_W-1:0] turn_off_target = pick(~in_s.delay_select, OFF_FAST, OFF_DELAY);
    wire [TMR_W-1:0] lockout_target = cyc(LOCKOUT);
    // an armed press outranks every other request
    wire press_start = button_fall & armed_r;

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        tmr_nxt = tmr_r + 30'h1;
        target_nxt = target_r;
        armed_nxt = armed_r;
        need_release_nxt = need_release_r;
        switch_on_nxt = switch_on_r;
        lockout_nxt = 1'b0;
        // release re-arms the press timer
        if (button_rise) begin
            armed_nxt = 1'b1;
        end
        unique case (state_r)
            ST_ON_IDLE: begin
                tmr_nxt = '0;
                if (press_start) begin
                    state_nxt = ST_LONG_PRESS;
                    target_nxt = press_target;
                end else if (wake_rise) begin
                    // already on: served, nothing to do
                    state_nxt = ST_ON_IDLE;
                end else if (shut_fall) begin
                    state_nxt = ST_OFF_WAIT;
                    // the 1 ms minimum low is the controller's duty; a rise aborts
                    target_nxt = turn_off_target;
                end
            end
            ST_OFF_WAIT: begin
                if (button_fall || wake_rise) begin
                    state_nxt = ST_ON_IDLE;
                    tmr_nxt = '0;
                    if (press_start) begin
                        state_nxt = ST_LONG_PRESS;
                        target_nxt = press_target;
                    end
                end else if (in_s.shutdown_request) begin
                    state_nxt = ST_ON_IDLE;
                    tmr_nxt = '0;
                end else if (tmr_done) begin
                    state_nxt = ST_OFF_IDLE;
                    switch_on_nxt = 1'b0;
                    tmr_nxt = '0;
                end
            end
            ST_LONG_PRESS: begin
                if (!button_low) begin
                    state_nxt = ST_ON_IDLE;
                    tmr_nxt = '0;
                end else if (tmr_done) begin
                    state_nxt = ST_LOCKOUT;
                    switch_on_nxt = 1'b0;
                    target_nxt = lockout_target;
                    // flag rises with the switch opening, so it stands the full count
                    lockout_nxt = 1'b1;
                    need_release_nxt = 1'b1;
                    armed_nxt = 1'b0;
                    tmr_nxt = '0;
                end
            end
            ST_LOCKOUT: begin
                lockout_nxt = 1'b1;
                if (tmr_done) begin
                    state_nxt = ST_OFF_IDLE;
                    lockout_nxt = 1'b0;
                    tmr_nxt = '0;
                end
            end
            ST_OFF_IDLE: begin
                tmr_nxt = '0;
                if (need_release_r) begin
                    // nothing accepted until the button is high again
                    if (in_s.power_button_n) need_release_nxt = 1'b0;
                end else if (button_low) begin
                    state_nxt = ST_ON_WAIT;
                    target_nxt = turn_on_target;
                end else if (in_s.wake_request) begin
                    state_nxt = ST_ON_IDLE;
                    switch_on_nxt = 1'b1;
                    armed_nxt = 1'b1;
                end
            end
            ST_ON_WAIT: begin
                if (!button_low) begin
                    state_nxt = ST_OFF_IDLE;
                    tmr_nxt = '0;
                    if (in_s.wake_request) begin
                        state_nxt = ST_ON_IDLE;
                        switch_on_nxt = 1'b1;
                        armed_nxt = 1'b1;
                    end
                end else if (tmr_done) begin
                    state_nxt = ST_ON_IDLE;
                    switch_on_nxt = 1'b1;
                    armed_nxt = 1'b0;
                    tmr_nxt = '0;
                end
            end
            default: begin
                state_nxt = ST_ON_IDLE;
                tmr_nxt = '0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= ST_ON_IDLE;
            prev_r <= '{RST_BUTTON_N, RST_WAKE, RST_SHUTDOWN, RST_DELAY_SEL};
            tmr_r <= '0;
            target_r <= '0;
            armed_r <= 1'b1;
            need_release_r <= 1'b0;
            switch_on_r <= RST_SWITCH_ON;
            lockout_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            prev_r <= in_s;
            tmr_r <= tmr_nxt;
            target_r <= target_nxt;
            armed_r <= armed_nxt;
            need_release_r <= need_release_nxt;
            switch_on_r <= switch_on_nxt;
            lockout_r <= lockout_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign switch_on = switch_on_r;
    assign lockout_active = lockout_r;
endmodule : lsr_sequencer

/* File: bench/lsr_asserts.sv */
// concurrent checks on the load switch reset sequencer ports
`timescale 1ns/1ps
module lsr_asserts
    import lsr_pkg::*;
#(
    parameter int unsigned OFF_DELAY = 20,
    parameter int unsigned LOCKOUT = 10
) (
    input wire logic clk, // system clock
    input wire logic reset, // synchronous reset
    input wire lsr_pkg::lsr_inputs_t pins, // raw pins
    input wire logic switch_on, // switch command
    input wire logic lockout_active // lock-out flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // --------
    // helper counters and the hold flag
    // --------
    int unsigned lock_cnt_r;
    int unsigned quiet_cnt_r;
    int unsigned sd_low_cnt_r;
    logic hold_r;
    always_ff @(posedge clk) begin
        lock_cnt_r <= lockout_active ? lock_cnt_r + 1 : 0;
        quiet_cnt_r <= (pins.power_button_n && pins.shutdown_request) ? quiet_cnt_r + 1 : 0;
        sd_low_cnt_r <= pins.shutdown_request ? 0 : sd_low_cnt_r + 1;
        // cleared on raw release: conservative, the design sees it later
        if (reset || pins.power_button_n) begin
            hold_r <= 1'b0;
        end else if ($rose(switch_on) && !$past(reset)) begin
            hold_r <= 1'b1;
        end
    end
    // --------
    // properties
    // --------
    property p_reset_on;
        $fell(reset) |-> switch_on && !lockout_active;
    endproperty
    a_reset_on: assert property (p_reset_on) else $error("switch not on after reset");
    property p_lock_len;
        $fell(lockout_active) && !$past(reset) |-> lock_cnt_r == LOCKOUT;
    endproperty
    a_lock_len: assert property (p_lock_len) else $error("lock-out length wrong");
    property p_lock_off;
        lockout_active |-> !switch_on;
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("switch on in lock-out");
    property p_stay_on;
        switch_on && quiet_cnt_r >= 4 |=> switch_on;
    endproperty
    a_stay_on: assert property (p_stay_on) else $error("switch dropped without request");
    property p_off_min;
        $fell(switch_on) && pins.power_button_n && pins.delay_select |-> sd_low_cnt_r >= OFF_DELAY;
    endproperty
    a_off_min: assert property (p_off_min) else $error("delayed turn-off too early");
    property p_fast_off;
        $fell(pins.shutdown_request) && !pins.delay_select && pins.power_button_n
            && !pins.wake_request && switch_on |-> ##[1:14] !switch_on;
    endproperty
    a_fast_off: assert property (p_fast_off) else $error("fast turn-off late");
    property p_fast_on;
        $fell(pins.power_button_n) && !pins.delay_select && !switch_on && !lockout_active
            |-> ##[1:14] switch_on;
    endproperty
    a_fast_on: assert property (p_fast_on) else $error("fast turn-on late");
    property p_held_no_reset;
        hold_r && !pins.power_button_n |-> switch_on;
    endproperty
    a_held_no_reset: assert property (p_held_no_reset) else $error("reset while still held");
    c_lock: cover property ($rose(lockout_active));
    c_off: cover property ($fell(switch_on));
    c_on: cover property ($rose(switch_on));
endmodule : lsr_asserts

/* File: bench/lsr_far_model.sv */
// far-side model: button, host and power controller driving the pins
`timescale 1ns/1ps
module lsr_far_model
    import lsr_pkg::*;
#(
    parameter int SD_MIN = 3
) (
    input wire logic clk, // system clock
    input wire lsr_pkg::lsr_inputs_t cmd, // wanted levels
    output lsr_pkg::lsr_inputs_t pins // driven levels
);
    int low_cnt_r = 0;
    initial pins = 4'hb;
    // pins move on the falling edge, away from the sampling edge
    wire hold_low = !pins.shutdown_request && low_cnt_r < SD_MIN;
    always @(negedge clk) begin
        pins <= '{cmd.power_button_n, cmd.wake_request, cmd.shutdown_request & ~hold_low, cmd.delay_select};
        low_cnt_r <= pins.shutdown_request ? 0 : low_cnt_r + 1;
    end
endmodule : lsr_far_model

/* File: bench/tb.sv */
// self-checking bench for the load switch reset sequencer
`timescale 1ns/1ps
module tb;
    import lsr_pkg::*;
    typedef struct {
        lsr_inputs_t p;
        int w;
        logic [1:0] e;
    } lsr_row_t;
    logic clk = 1'b0;
    logic reset = 1'b1;
    lsr_inputs_t cmd = 4'hb;
    lsr_inputs_t pins;
    logic switch_on;
    logic lockout_active;
    int miscompares = 0;
    int samples_checked = 0;
    int n;
    // scaled-down delays keep the run short
    localparam int unsigned T_OFF = 20;
    localparam int unsigned T_OFF_FAST = 5;
    localparam int unsigned T_ON = 20;
    localparam int unsigned T_ON_FAST = 5;
    localparam int unsigned T_LONG = 40;
    localparam int unsigned T_LONG_FAST = 5;
    localparam int unsigned T_LOCK = 10;
    // pins, cycles held, then {switch_on, lockout_active}
    lsr_row_t rows [33] = '{
        '{4'hb, 10, 2'h2}, '{4'h9, 10, 2'h2},
        '{4'h9, 20, 2'h0}, '{4'hb, 10, 2'h0},
        '{4'hf, 12, 2'h2}, '{4'hb, 6, 2'h2},
        '{4'ha, 6, 2'h2}, '{4'h8, 13, 2'h0},
        '{4'hb, 6, 2'h0}, '{4'h3, 10, 2'h0}, '{4'h3, 20, 2'h2},
        '{4'h3, 50, 2'h2}, '{4'hb, 6, 2'h2},
        '{4'h3, 20, 2'h2}, '{4'hb, 6, 2'h2},
        '{4'h3, 30, 2'h2}, '{4'h3, 16, 2'h1},
        '{4'h3, 12, 2'h0}, '{4'h3, 25, 2'h0},
        '{4'hb, 6, 2'h0}, '{4'hf, 12, 2'h2},
        '{4'ha, 6, 2'h2}, '{4'h2, 12, 2'h1},
        '{4'h6, 4, 2'h1}, '{4'h2, 10, 2'h0},
        '{4'ha, 6, 2'h0}, '{4'h2, 12, 2'h2},
        '{4'hb, 6, 2'h2}, '{4'h9, 10, 2'h2},
        '{4'hd, 30, 2'h2}, '{4'hb, 6, 2'h2},
        '{4'h1, 8, 2'h2}, '{4'h9, 30, 2'h2}
    };
    always #10 clk = ~clk;
    lsr_far_model far (.clk(clk), .cmd(cmd), .pins(pins));
    lsr_sequencer #(.OFF_DELAY(T_OFF), .OFF_FAST(T_OFF_FAST), .ON_DELAY(T_ON), .ON_FAST(T_ON_FAST),
        .LONG_PRESS(T_LONG), .LONG_FAST(T_LONG_FAST), .LOCKOUT(T_LOCK)) uut (.clk(clk), .reset(reset), .pins(pins),
        .switch_on(switch_on), .lockout_active(lockout_active));
    task automatic check(input logic [1:0] got, input logic [1:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: %s got %b want %b", $time, m, got, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (5) @(negedge clk);
        reset = 1'b0;
        foreach (rows[i]) begin
            @(posedge clk) cmd = rows[i].p;
            repeat (rows[i].w) @(posedge clk);
            @(negedge clk) check({switch_on, lockout_active}, rows[i].e, $sformatf("step %0d", i));
        end
        $display("step table done");
        // shutdown held low across a reset
        @(posedge clk) cmd = 4'h9;
        @(negedge clk) reset = 1'b1;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        @(negedge clk) check({switch_on, lockout_active}, 2'h2, "after reset");
        n = 0;
        while (switch_on !== 1'b0 && n < 60) begin
            @(negedge clk);
            n++;
        end
        check({1'b0, n >= 20 && n <= 28}, 2'h1, "off delay after reset");
        $display("reset test done");
        give_verdict();
    end
endmodule : tb
bind lsr_sequencer lsr_asserts #(.OFF_DELAY(OFF_DELAY), .LOCKOUT(LOCKOUT)) chk (.clk(clk), .reset(reset),
    .pins(pins), .switch_on(switch_on), .lockout_active(lockout_active));
